/* File: src/lvd_cfg.svh */
// Offsets, bit positions, reset values and timing constants of the low-voltage detector
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LVD_ADDR_CTRL 16'hFFBE
`define LVD_ADDR_LEVEL 16'hFFBF
`define LVD_ADDR_RSRC 16'hFFA8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LVD_BIT_ENABLE 7
`define LVD_BIT_SOURCE 2
`define LVD_BIT_ACTION 1
`define LVD_BIT_FLAG 0
`define LVD_BIT_RSRC_FLAG 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LVD_CTRL_RESET 3'h0
`define LVD_LEVEL_RESET 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define LVD_CLK_MHZ 40
`define LVD_SETTLE_US 10
`define LVD_FILTER_US 200
// Whole MHz clock, so the product is exact and needs no rounding
`define LVD_US_TO_CYCLES(us) ((us) * `LVD_CLK_MHZ)

`endif

/* File: src/lvd_pkg.sv */
// Types and shared bit-merge function of the low-voltage detector
package lvd_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [3:0] level_t;

    typedef struct packed {
        logic enable;
        logic source;
        logic action;
    } ctrl_s;

    typedef enum logic [1:0] {
        ACC_NONE = 2'b00,
        ACC_BYTE = 2'b01,
        ACC_BIT = 2'b11
    } acc_e;

    // Replace one bit of a byte, the others untouched
    function automatic byte_t bit_merge(byte_t old, logic [2:0] sel, logic val);
        byte_t res;
        res = old;
        res[sel] = val;
        return res;
    endfunction

endpackage

/* File: src/lvd_if.sv */
// Carrier between the control logic and the below-level filter
`timescale 1ns/1ps
interface lvd_if;
    logic enable;
    logic below;
    logic filtered;

    modport ctrl (output enable, output below, input filtered);
    modport filter (input enable, input below, output filtered);
endinterface

/* File: src/lvd_filter.sv */
// Settling mask and minimum below-level width filter
`timescale 1ns/1ps
`include "lvd_cfg.svh"
module lvd_filter
    import lvd_pkg::*;
#(
    parameter int FILTER_CYCLES = `LVD_US_TO_CYCLES(`LVD_FILTER_US),
    parameter int SETTLE_CYCLES = `LVD_US_TO_CYCLES(`LVD_SETTLE_US)
)
(
    input wire logic clock,
    input wire logic rst_b,
    lvd_if.filter port
);

    localparam int MAXC = (FILTER_CYCLES > SETTLE_CYCLES) ? FILTER_CYCLES : SETTLE_CYCLES;
    localparam int W = $clog2(MAXC + 1);
    localparam logic [W-1:0] SETTLE_LAST = W'(SETTLE_CYCLES);
    localparam logic [W-1:0] FILTER_LAST = W'(FILTER_CYCLES - 1);

    logic [W-1:0] settle_q;
    logic [W-1:0] run_q;
    logic out_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire settle_done = (settle_q == SETTLE_LAST);
    wire run_hit = (run_q == FILTER_LAST);

    // Comparator output is ignored while it settles after enable
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            settle_q <= '0;
            run_q <= '0;
            out_q <= 1'b0;
        end
        else if (!port.enable)
        begin
            settle_q <= '0;
            run_q <= '0;
            out_q <= 1'b0;
        end
        else if (!settle_done)
        begin
            settle_q <= settle_q + 1'b1;
        end
        else if (port.below)
        begin
            if (run_hit)
                out_q <= 1'b1;
            else
                run_q <= run_q + 1'b1;
        end
        else
        begin
            // Recovery is reported at once; only drops are filtered
            run_q <= '0;
            out_q <= 1'b0;
        end
    end

    assign port.filtered = out_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_filter_width;
        @(posedge clock) disable iff (!rst_b)
        $rose(out_q) |-> ($past(port.below) && ($past(run_q) == FILTER_LAST));
    endproperty
    a_filter_width: assert property (p_filter_width) else $error("flag set before minimum width");

    property p_filter_off;
        @(posedge clock) disable iff (!rst_b)
        !port.enable |=> (!out_q && (settle_q == '0));
    endproperty
    a_filter_off: assert property (p_filter_off) else $error("filter active while disabled");

endmodule // lvd_filter

/* File: src/low_voltage_detect_control.sv */
// Control and status logic of the low-voltage detector
//
// Overview of operation
// - Control bit 2 selects supply against threshold, or monitor pin against reference.
// - Reset mode holds reset request while voltage below threshold, releases at or above.
// - Interrupt mode pulses detector interrupt on both falling below and recovering.
// - While enabled, control bit 0 reads 1 below threshold, else 0.
// - Flag reads 0 whenever detection is disabled.
// - Reset caused by this detector sets reset-source flag bit 0.
// - Any other reset clears the whole control register.
// - Own reset keeps enable, source and action bits unchanged.
// - Control bit 0 is read-only; writes never alter it.
// - Enable bit 7 starts comparator; output untrusted for 10 us afterwards.
// - Flag sets only after voltage stays below threshold for 200 us.
// - Interrupt mode: disabling while below raises interrupt and its request flag.
// - Control register accepts single-bit and whole-byte writes.
// - Supply threshold selectable among 16 levels and passed to comparator.
// - Threshold register holds 4-bit code in bits 3..0; bits 7..4 zero.
// - Threshold register survives own reset, cleared by every other reset.
// - Setting reset mode while voltage is fine gives no reset request.
`timescale 1ns/1ps
`include "lvd_cfg.svh"
module low_voltage_detect_control
    import lvd_pkg::*;
#(
    parameter int FILTER_CYCLES = `LVD_US_TO_CYCLES(`LVD_FILTER_US),
    parameter int SETTLE_CYCLES = `LVD_US_TO_CYCLES(`LVD_SETTLE_US)
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic other_reset,
    input wire logic cmp_below,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr_byte,
    input wire logic bus_wr_bit,
    input wire logic [2:0] bus_bit_sel,
    input wire logic bus_bit_val,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_rd,
    input wire logic irq_flag_clear,
    output logic [7:0] bus_rdata,
    output logic comparator_enable,
    output logic source_select,
    output logic [3:0] supply_threshold,
    output logic detector_reset_request,
    output logic detector_interrupt,
    output logic detector_interrupt_request_flag,
    output logic detector_reset_source_flag
);

    logic rst_meta_q;
    logic rst_sync_q;
    logic cmp_meta_q;
    logic cmp_sync_q;
    ctrl_s ctrl_q;
    level_t level_q;
    logic below_flag_q;
    logic reset_req_q;
    logic irq_q;
    logic irq_flag_q;
    logic rsrc_flag_q;
    byte_t rdata_q;
    lvd_if det_if();

    // ----------------------------------------
    // Reset release and comparator synchroniser
    // ----------------------------------------
    wire rst_sync_b = rst_sync_q;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Clock is never gated here, so detection carries on in stop mode
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end
        else
        begin
            cmp_meta_q <= cmp_below;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire hit_ctrl = (bus_addr == `LVD_ADDR_CTRL);
    wire hit_level = (bus_addr == `LVD_ADDR_LEVEL);
    wire hit_rsrc = (bus_addr == `LVD_ADDR_RSRC);
    wire acc_e acc = acc_e'(bus_wr_bit ? ACC_BIT : (bus_wr_byte ? ACC_BYTE : ACC_NONE));
    wire byte_t ctrl_view = {ctrl_q.enable, 4'h0, ctrl_q.source, ctrl_q.action, below_flag_q};
    wire byte_t level_view = {4'h0, level_q};
    // Bit writes merge into the current view, so other bits stay put
    wire byte_t ctrl_new = (acc == ACC_BIT) ? bit_merge(ctrl_view, bus_bit_sel, bus_bit_val)
                                            : bus_wdata;
    wire byte_t level_new = (acc == ACC_BIT) ? bit_merge(level_view, bus_bit_sel, bus_bit_val)
                                             : bus_wdata;
    wire ctrl_wr = hit_ctrl && (acc != ACC_NONE);
    wire level_wr = hit_level && (acc != ACC_NONE);
    wire rsrc_read = hit_rsrc && bus_rd;
    // Bit 0 of the written byte is dropped: the flag is comparison-driven only
    wire ctrl_s ctrl_d = '{enable: ctrl_new[`LVD_BIT_ENABLE], source: ctrl_new[`LVD_BIT_SOURCE],
                           action: ctrl_new[`LVD_BIT_ACTION]};
    wire byte_t rdata_d = !bus_rd ? 8'h00 :
                          hit_ctrl ? ctrl_view :
                          hit_level ? level_view :
                          hit_rsrc ? {7'h00, rsrc_flag_q} : 8'h00;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Own reset request never reaches here, so configuration survives it
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ctrl_q <= `LVD_CTRL_RESET;
            level_q <= `LVD_LEVEL_RESET;
        end
        else if (other_reset)
        begin
            ctrl_q <= `LVD_CTRL_RESET;
            level_q <= `LVD_LEVEL_RESET;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_q <= ctrl_d;
            if (level_wr)
                level_q <= level_new[3:0];
        end
    end

    // ----------------------------------------
    // Filter and detection flag
    // ----------------------------------------
    assign det_if.enable = ctrl_q.enable;
    assign det_if.below = cmp_sync_q;

    lvd_filter #(
        .FILTER_CYCLES(FILTER_CYCLES),
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_filter (
        .clock(clock),
        .rst_b(rst_sync_b),
        .port(det_if.filter)
    );

    wire flag_d = ctrl_q.enable && det_if.filtered;
    // A fall of the flag on disable counts as an edge too
    wire irq_d = (flag_d != below_flag_q) && !ctrl_q.action;

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            below_flag_q <= 1'b0;
            reset_req_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            below_flag_q <= flag_d;
            reset_req_q <= ctrl_q.action && below_flag_q;
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------
    // Sticky flags, set wins over clear
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            irq_flag_q <= 1'b0;
            rsrc_flag_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            if (irq_d)
                irq_flag_q <= 1'b1;
            else if (irq_flag_clear || other_reset)
                irq_flag_q <= 1'b0;
            // Other internal resets leave the source flag held
            if (reset_req_q)
                rsrc_flag_q <= 1'b1;
            else if (rsrc_read)
                rsrc_flag_q <= 1'b0;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign bus_rdata = rdata_q;
    assign comparator_enable = ctrl_q.enable;
    assign source_select = ctrl_q.source;
    assign supply_threshold = level_q;
    assign detector_reset_request = reset_req_q;
    assign detector_interrupt = irq_q;
    assign detector_interrupt_request_flag = irq_flag_q;
    assign detector_reset_source_flag = rsrc_flag_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_flag_off;
        @(posedge clock) disable iff (!rst_sync_b)
        !ctrl_q.enable |=> !below_flag_q;
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag set while disabled");

    property p_reset_hold;
        @(posedge clock) disable iff (!rst_sync_b)
        (ctrl_q.action && below_flag_q) |=> detector_reset_request;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset request missing");

    property p_no_reset_above;
        @(posedge clock) disable iff (!rst_sync_b)
        !below_flag_q |=> !detector_reset_request;
    endproperty
    a_no_reset_above: assert property (p_no_reset_above) else $error("reset while above");

    property p_irq_edge;
        @(posedge clock) disable iff (!rst_sync_b)
        ($changed(below_flag_q) && !$past(ctrl_q.action)) |-> (detector_interrupt && irq_flag_q);
    endproperty
    a_irq_edge: assert property (p_irq_edge) else $error("edge without interrupt");

    sequence s_disable_below;
        $fell(ctrl_q.enable) && below_flag_q && !ctrl_q.action;
    endsequence
    sequence s_irq_raised;
        detector_interrupt && detector_interrupt_request_flag;
    endsequence
    property p_irq_disable;
        @(posedge clock) disable iff (!rst_sync_b)
        s_disable_below |=> s_irq_raised;
    endproperty
    a_irq_disable: assert property (p_irq_disable) else $error("disable gave no interrupt");

    property p_rsrc_set;
        @(posedge clock) disable iff (!rst_sync_b)
        detector_reset_request |=> detector_reset_source_flag;
    endproperty
    a_rsrc_set: assert property (p_rsrc_set) else $error("source flag not set");

    property p_other_clear;
        @(posedge clock) disable iff (!rst_sync_b)
        other_reset |=> ((ctrl_q == '0) && (level_q == '0));
    endproperty
    a_other_clear: assert property (p_other_clear) else $error("other reset left state");

    property p_bit_write;
        @(posedge clock) disable iff (!rst_sync_b)
        (hit_ctrl && bus_wr_bit && (bus_bit_sel == 3'h2) && !other_reset)
        |=> ((ctrl_q.source == $past(bus_bit_val)) && $stable(ctrl_q.enable)
             && $stable(ctrl_q.action));
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write disturbed others");

endmodule // low_voltage_detect_control

/* File: dv/lvd_comparator_model.sv */
// Behavioural analogue comparator facing the detector control block
`timescale 1ns/1ps
module lvd_comparator_model
(
    input wire logic clock,
    input wire logic enable,
    input wire logic source_select,
    input wire logic [3:0] supply_threshold,
    input wire logic [4:0] supply_rank,
    input wire logic ext_low,
    output logic cmp_below
);
    logic idle_q = 1'b0;
    logic live_w;

    // Rank grows as supply sinks; equal rank sits at the level, not below
    assign live_w = source_select ? ext_low : (supply_rank > {1'b0, supply_threshold});

    // A stopped comparator gives no usable answer, so it wanders
    always @(posedge clock)
    begin
        idle_q <= ~idle_q;
    end

    assign cmp_below = enable ? live_w : idle_q;
endmodule // lvd_comparator_model

/* File: dv/low_voltage_detect_control_tb_top.sv */
// Self-checking bench for the low-voltage detector control block
`timescale 1ns/1ps
`include "lvd_cfg.svh"
module low_voltage_detect_control_tb_top;
    localparam int FILT = 20;
    localparam int SETL = 5;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic other_reset = 1'b0;
    logic cmp_below;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_wr_byte = 1'b0;
    logic bus_wr_bit = 1'b0;
    logic [2:0] bus_bit_sel = 3'h0;
    logic bus_bit_val = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_rd = 1'b0;
    logic irq_flag_clear = 1'b0;
    logic [7:0] bus_rdata;
    logic comparator_enable;
    logic source_select;
    logic [3:0] supply_threshold;
    logic detector_reset_request;
    logic detector_interrupt;
    logic detector_interrupt_request_flag;
    logic detector_reset_source_flag;
    logic [4:0] supply_rank = 5'h00;
    logic ext_low = 1'b0;
    int err_total = 0;
    int checks = 0;
    int waited = 0;

    // ----------------------------------------
    // Clock, design and far side
    // ----------------------------------------
    always #12.5 clock = ~clock;

    low_voltage_detect_control #(.FILTER_CYCLES(FILT), .SETTLE_CYCLES(SETL)) dut
    (
        .clock(clock), .rst_b(rst_b), .other_reset(other_reset), .cmp_below(cmp_below),
        .bus_addr(bus_addr), .bus_wr_byte(bus_wr_byte), .bus_wr_bit(bus_wr_bit),
        .bus_bit_sel(bus_bit_sel), .bus_bit_val(bus_bit_val), .bus_wdata(bus_wdata),
        .bus_rd(bus_rd), .irq_flag_clear(irq_flag_clear), .bus_rdata(bus_rdata),
        .comparator_enable(comparator_enable), .source_select(source_select),
        .supply_threshold(supply_threshold), .detector_reset_request(detector_reset_request),
        .detector_interrupt(detector_interrupt),
        .detector_interrupt_request_flag(detector_interrupt_request_flag),
        .detector_reset_source_flag(detector_reset_source_flag)
    );

    lvd_comparator_model model
    (
        .clock(clock), .enable(comparator_enable), .source_select(source_select),
        .supply_threshold(supply_threshold), .supply_rank(supply_rank),
        .ext_low(ext_low), .cmp_below(cmp_below)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr_byte <= 1'b1;
        @(posedge clock);
        bus_wr_byte <= 1'b0;
    endtask

    task automatic wr_bit(input logic [15:0] a, input logic [2:0] s, input logic v);
        @(posedge clock);
        bus_addr <= a;
        bus_bit_sel <= s;
        bus_bit_val <= v;
        bus_wr_bit <= 1'b1;
        @(posedge clock);
        bus_wr_bit <= 1'b0;
    endtask

    // Read data lands one cycle after the strobe edge
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string msg);
        @(posedge clock);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1;
        check(bus_rdata, exp, msg);
    endtask

    // Bounded wait: 0 interrupt pulse, 1 request high, 2 request low
    task automatic wait_for(input int sel);
        logic hit;
        hit = 1'b0;
        waited = 0;
        while (!hit)
        begin
            @(posedge clock);
            #1;
            waited++;
            case (sel)
                0: hit = (detector_interrupt === 1'b1);
                1: hit = (detector_reset_request === 1'b1);
                default: hit = (detector_reset_request === 1'b0);
            endcase
            if (waited > 400)
            begin
                err_total++;
                $display("[FAIL] %0t wait ran out", $time);
                wrap_up();
            end
        end
    endtask

    task automatic clear_irq();
        @(posedge clock);
        irq_flag_clear <= 1'b1;
        @(posedge clock);
        irq_flag_clear <= 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        rd(`LVD_ADDR_CTRL, 8'h00, "ctrl reset");
        rd(`LVD_ADDR_LEVEL, 8'h00, "level reset");
        rd(`LVD_ADDR_RSRC, 8'h00, "source reset");
        rd(16'hFFC0, 8'h00, "unmapped");
    endtask

    task automatic t_registers();
        wr(`LVD_ADDR_CTRL, 8'h7F);
        rd(`LVD_ADDR_CTRL, 8'h06, "byte write");
        wr_bit(`LVD_ADDR_CTRL, 3'h2, 1'b0);
        rd(`LVD_ADDR_CTRL, 8'h02, "bit clear");
        check({7'h00, source_select}, 8'h00, "source out");
        wr_bit(`LVD_ADDR_CTRL, 3'h0, 1'b1);
        rd(`LVD_ADDR_CTRL, 8'h02, "flag write");
        wr(`LVD_ADDR_CTRL, 8'h00);
        rd(`LVD_ADDR_CTRL, 8'h00, "stop byte");
        // Upper nibble written as ones to prove it is dropped
        for (int i = 0; i < 16; i++)
        begin
            wr(`LVD_ADDR_LEVEL, {4'hF, 4'(i)});
            rd(`LVD_ADDR_LEVEL, {4'h0, 4'(i)}, "level");
            check({4'h0, supply_threshold}, {4'h0, 4'(i)}, "level out");
        end
        wr_bit(`LVD_ADDR_LEVEL, 3'h7, 1'b1);
        rd(`LVD_ADDR_LEVEL, 8'h0F, "level bit 7");
    endtask

    task automatic t_interrupt();
        wr(`LVD_ADDR_LEVEL, 8'h03);
        wr(`LVD_ADDR_CTRL, 8'h80);
        repeat (SETL + 5) @(posedge clock);
        rd(`LVD_ADDR_CTRL, 8'h80, "above");
        check({7'h00, comparator_enable}, 8'h01, "enable out");
        @(posedge clock);
        supply_rank <= 5'h05;
        wait_for(0);
        check({7'h00, waited >= FILT}, 8'h01, "filter width");
        @(posedge clock);
        #1;
        check({7'h00, detector_interrupt_request_flag}, 8'h01, "irq fall");
        rd(`LVD_ADDR_CTRL, 8'h81, "below");
        clear_irq();
        // Equal rank is at the level, so this is a recovery
        supply_rank <= 5'h03;
        wait_for(0);
        rd(`LVD_ADDR_CTRL, 8'h80, "recovered");
        @(posedge clock);
        supply_rank <= 5'h09;
        wait_for(0);
        clear_irq();
        wr_bit(`LVD_ADDR_CTRL, 3'h7, 1'b0);
        wait_for(0);
        @(posedge clock);
        #1;
        check({7'h00, detector_interrupt_request_flag}, 8'h01, "irq stop");
        rd(`LVD_ADDR_CTRL, 8'h00, "disabled");
        check({7'h00, comparator_enable}, 8'h00, "enable off");
    endtask

    task automatic t_reset_mode();
        wr(`LVD_ADDR_LEVEL, 8'h0A);
        wr(`LVD_ADDR_CTRL, 8'h86);
        // Reset mode: control left untouched while enabled
        repeat (SETL + FILT + 15) @(posedge clock);
        check({7'h00, detector_reset_request}, 8'h00, "no request");
        ext_low <= 1'b1;
        wait_for(1);
        repeat (2) @(posedge clock);
        #1;
        check({7'h00, detector_reset_source_flag}, 8'h01, "source flag");
        rd(`LVD_ADDR_CTRL, 8'h87, "kept ctrl");
        rd(`LVD_ADDR_LEVEL, 8'h0A, "kept level");
        @(posedge clock);
        ext_low <= 1'b0;
        wait_for(2);
        rd(`LVD_ADDR_RSRC, 8'h01, "source read");
        rd(`LVD_ADDR_RSRC, 8'h00, "source cleared");
        @(posedge clock);
        other_reset <= 1'b1;
        @(posedge clock);
        other_reset <= 1'b0;
        rd(`LVD_ADDR_CTRL, 8'h00, "other ctrl");
        rd(`LVD_ADDR_LEVEL, 8'h00, "other level");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset_values();
        t_registers();
        t_interrupt();
        t_reset_mode();
        wrap_up();
    end
endmodule // low_voltage_detect_control_tb_top
